//--- rtl/scr_pkg.sv
// Shared constants and types for the sensor configuration register group
package scr_pkg;

  // Register addresses on the internal register port
  localparam logic [7:0] ADDR_CLIENT = 8'h3f;
  localparam logic [7:0] ADDR_FILTER = 8'h40;
  localparam logic [7:0] ADDR_CHTYPE = 8'h42;
  localparam logic [7:0] ADDR_INTPIN = 8'h43;

  // Storage indexes
  localparam int unsigned REG_COUNT = 4;
  localparam logic [1:0] IDX_CLIENT = 2'h0;
  localparam logic [1:0] IDX_FILTER = 2'h1;
  localparam logic [1:0] IDX_CHTYPE = 2'h2;
  localparam logic [1:0] IDX_INTPIN = 2'h3;

  // Reset values
  localparam logic [7:0] RST_CLIENT = 8'h00;
  localparam logic [7:0] RST_FILTER = 8'h30;
  localparam logic [7:0] RST_CHTYPE = 8'h00;
  localparam logic [7:0] RST_INTPIN = 8'h00;

  // Client address substitution
  localparam logic [7:0] CLIENT_UNSET = 8'h00;
  localparam logic [6:0] DEFAULT_CLIENT_ADDR = 7'h60;
  localparam logic [7:0] DEFAULT_CLIENT_READ = 8'h60;

  // Field positions
  localparam int unsigned CLIENT_MSB = 6;
  localparam int unsigned FILTER_MSB = 7;
  localparam int unsigned FILTER_LSB = 4;
  localparam int unsigned CH0_MSB = 6;
  localparam int unsigned CH0_LSB = 5;
  localparam int unsigned CH1_MSB = 3;
  localparam int unsigned CH1_LSB = 2;
  localparam int unsigned INT_MODE_BIT = 2;

  // Field encodings
  localparam logic [3:0] FILTER_800HZ = 4'h2;
  localparam logic [3:0] FILTER_1000HZ = 4'h3;
  localparam logic [1:0] TYPE_PRESSURE = 2'h1;
  localparam logic [1:0] TYPE_TEMPERATURE = 2'h3;

  // Unmapped reads return this
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Signal path restart time; least time, so cycles round up
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RESTART_TIME_NS = 1000;
  localparam int unsigned RESTART_CYCLES = (RESTART_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESTART_CNT_W = 8;
  localparam logic [RESTART_CNT_W-1:0] RESTART_LAST = RESTART_CNT_W'(RESTART_CYCLES - 1);
  localparam logic [RESTART_CNT_W-1:0] RESTART_ZERO = 8'h00;

  typedef logic [REG_COUNT-1:0][7:0] scr_array_t;

  localparam scr_array_t RST_ARRAY = {RST_INTPIN, RST_CHTYPE, RST_FILTER, RST_CLIENT};

  // Array check seed keeps an all-zero array from checking as zero
  localparam logic [7:0] CHECK_SEED = 8'h5a;

  typedef enum logic [1:0] {
    SCR_RUN = 2'b00,
    SCR_RESTART = 2'b01
  } scr_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scr_req_t;

  typedef struct packed {
    logic [6:0] client_addr;
    logic [3:0] filter_sel;
    logic [1:0] ch0_type;
    logic [1:0] ch1_type;
    logic int_active_low;
  } scr_cfg_t;

endpackage : scr_pkg

//--- rtl/scr_array_check.sv
// Error check over the read/write configuration array
`timescale 1ns/1ns
`default_nettype none
module scr_array_check
  import scr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_capture,
  input wire scr_array_t i_next_array,
  input wire scr_array_t i_array,
  output logic o_mismatch
);

  logic [7:0] stored;
  logic [7:0] next_stored;
  logic next_mismatch;

  function automatic logic [7:0] fold(input scr_array_t a);
    logic [7:0] acc;
    acc = CHECK_SEED;
    for (int i = 0; i < REG_COUNT; i++) begin
      acc = acc ^ a[i];
    end
    return acc;
  endfunction : fold

  // Check byte follows every accepted write; a flipped storage bit then disagrees
  always_comb begin
    next_stored = i_capture ? fold(i_next_array) : stored;
    next_mismatch = (fold(i_array) != stored);
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stored <= CHECK_SEED ^ RST_CLIENT ^ RST_FILTER ^ RST_CHTYPE ^ RST_INTPIN;
      o_mismatch <= 1'b0;
    end else begin
      stored <= next_stored;
      o_mismatch <= next_mismatch;
    end
  end

endmodule : scr_array_check
`default_nettype wire

//--- rtl/scr_config_regs.sv
// Sensor configuration registers: client address, filter, channel types, pin mode
// What this block does
// - Zero address register answers and reads 60h
// - Nonzero: low seven bits address, read unchanged
// - Address register readable in every mode
// - All four registers covered by array check
// - Filter or type change restarts signal path
// - Filter field: 0010 800 Hz, 0011 1000 Hz
// - Reset returns filter to 1000 Hz
// - Undefined filter code flags status error
// - Channel 0 type: 01 pressure, 11 temperature
// - Channel 1 type: 01 pressure, 11 temperature
// - Bit 2 selects interrupt pin polarity
// - Init lock blocks all writes here
`timescale 1ns/1ns
`default_nettype none
module scr_config_regs
  import scr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire scr_req_t i_req,
  input wire logic i_init_lock,
  output logic [7:0] o_rdata,
  output logic o_rd_valid,
  output scr_cfg_t o_cfg,
  output logic o_path_restart,
  output logic o_path_busy,
  output logic o_data_valid,
  output logic o_filter_err,
  output logic o_array_err
);

  scr_array_t regs;
  scr_array_t next_regs;
  logic [1:0] idx;
  logic hit;
  logic wr_ok;
  logic path_change;

  scr_state_t state;
  scr_state_t next_state;
  logic [RESTART_CNT_W-1:0] cnt;
  logic [RESTART_CNT_W-1:0] next_cnt;

  logic [7:0] next_rdata;
  logic next_rd_valid;
  scr_cfg_t next_cfg;
  logic next_path_restart;
  logic next_path_busy;
  logic next_data_valid;
  logic next_filter_err;

  // Address decode and write acceptance
  always_comb begin
    idx = IDX_CLIENT;
    hit = 1'b1;
    unique case (i_req.addr)
      ADDR_CLIENT: idx = IDX_CLIENT;
      ADDR_FILTER: idx = IDX_FILTER;
      ADDR_CHTYPE: idx = IDX_CHTYPE;
      ADDR_INTPIN: idx = IDX_INTPIN;
      default: hit = 1'b0;
    endcase
    wr_ok = i_req.wr && hit && !i_init_lock;
    next_regs = regs;
    if (wr_ok) begin
      next_regs[idx] = i_req.wdata;
    end
    // Rewriting the same value leaves the filter running
    path_change = wr_ok && ((idx == IDX_FILTER) || (idx == IDX_CHTYPE))
                  && (i_req.wdata != regs[idx]);
  end

  for (genvar g = 0; g < REG_COUNT; g++) begin : g_reg
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
        regs[g] <= RST_ARRAY[g];
      end else begin
        regs[g] <= next_regs[g];
      end
    end
  end

  // Signal path restart sequencer; a change during restart starts it over
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      SCR_RUN: begin
        if (path_change) begin
          next_state = SCR_RESTART;
          next_cnt = RESTART_LAST;
        end
      end
      SCR_RESTART: begin
        if (path_change) begin
          next_cnt = RESTART_LAST;
        end else if (cnt == RESTART_ZERO) begin
          next_state = SCR_RUN;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: begin
        next_state = SCR_RUN;
        next_cnt = RESTART_ZERO;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= SCR_RUN;
      cnt <= RESTART_ZERO;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Read path and registered outputs
  always_comb begin
    next_rd_valid = i_req.rd;
    next_rdata = READ_UNMAPPED;
    if (i_req.rd && hit) begin
      if (idx == IDX_CLIENT && regs[IDX_CLIENT] == CLIENT_UNSET) begin
        next_rdata = DEFAULT_CLIENT_READ;
      end else begin
        next_rdata = regs[idx];
      end
    end
    if (next_regs[IDX_CLIENT] == CLIENT_UNSET) begin
      next_cfg.client_addr = DEFAULT_CLIENT_ADDR;
    end else begin
      next_cfg.client_addr = next_regs[IDX_CLIENT][CLIENT_MSB:0];
    end
    next_cfg.filter_sel = next_regs[IDX_FILTER][FILTER_MSB:FILTER_LSB];
    next_cfg.ch0_type = next_regs[IDX_CHTYPE][CH0_MSB:CH0_LSB];
    next_cfg.ch1_type = next_regs[IDX_CHTYPE][CH1_MSB:CH1_LSB];
    next_cfg.int_active_low = next_regs[IDX_INTPIN][INT_MODE_BIT];
    next_filter_err = (next_cfg.filter_sel != FILTER_800HZ)
                      && (next_cfg.filter_sel != FILTER_1000HZ);
    next_path_restart = path_change;
    next_path_busy = (next_state == SCR_RESTART);
    // Data valid drops with busy so the host can hold off sensor reads
    next_data_valid = !next_path_busy;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= READ_UNMAPPED;
      o_rd_valid <= 1'b0;
      o_cfg <= '{client_addr: DEFAULT_CLIENT_ADDR,
                 filter_sel: RST_FILTER[FILTER_MSB:FILTER_LSB],
                 ch0_type: RST_CHTYPE[CH0_MSB:CH0_LSB],
                 ch1_type: RST_CHTYPE[CH1_MSB:CH1_LSB],
                 int_active_low: RST_INTPIN[INT_MODE_BIT]};
      o_filter_err <= 1'b0;
      o_path_restart <= 1'b0;
      o_path_busy <= 1'b0;
      o_data_valid <= 1'b1;
    end else begin
      o_rdata <= next_rdata;
      o_rd_valid <= next_rd_valid;
      o_cfg <= next_cfg;
      o_filter_err <= next_filter_err;
      o_path_restart <= next_path_restart;
      o_path_busy <= next_path_busy;
      o_data_valid <= next_data_valid;
    end
  end

  scr_array_check u_check (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_capture(wr_ok),
    .i_next_array(next_regs),
    .i_array(regs),
    .o_mismatch(o_array_err)
  );

  // Helper: busy length since the latest restart pulse
  logic [RESTART_CNT_W-1:0] h_run;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      h_run <= RESTART_ZERO;
    end else if (o_path_restart) begin
      h_run <= RESTART_CNT_W'(1);
    end else if (o_path_busy) begin
      h_run <= h_run + 1'b1;
    end
  end

  property p_default_addr;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (regs[IDX_CLIENT] == CLIENT_UNSET) |-> (o_cfg.client_addr == DEFAULT_CLIENT_ADDR);
  endproperty
  a_default_addr: assert property (p_default_addr) else $error("default address wrong");

  property p_read_default;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_req.rd && i_req.addr == ADDR_CLIENT && regs[IDX_CLIENT] == CLIENT_UNSET)
      |=> (o_rd_valid && o_rdata == DEFAULT_CLIENT_READ);
  endproperty
  a_read_default: assert property (p_read_default) else $error("default read wrong");

  property p_read_stored;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_req.rd && i_req.addr == ADDR_CLIENT && regs[IDX_CLIENT] != CLIENT_UNSET)
      |=> (o_rdata == $past(regs[IDX_CLIENT]));
  endproperty
  a_read_stored: assert property (p_read_stored) else $error("stored read wrong");

  property p_addr_low7;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (regs[IDX_CLIENT] != CLIENT_UNSET) |-> (o_cfg.client_addr == regs[IDX_CLIENT][CLIENT_MSB:0]);
  endproperty
  a_addr_low7: assert property (p_addr_low7) else $error("client address not low bits");

  property p_read_locked;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_req.rd && i_init_lock) |=> o_rd_valid;
  endproperty
  a_read_locked: assert property (p_read_locked) else $error("read refused");

  property p_array_ok;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      !o_array_err;
  endproperty
  a_array_ok: assert property (p_array_ok) else $error("array check mismatch");

  property p_restart_start;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (path_change) |=> (o_path_restart && o_path_busy && !o_data_valid);
  endproperty
  a_restart_start: assert property (p_restart_start) else $error("restart not started");

  property p_restart_len;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      $fell(o_path_busy) |-> (h_run == RESTART_CNT_W'(RESTART_CYCLES));
  endproperty
  a_restart_len: assert property (p_restart_len) else $error("restart length wrong");

  property p_filter_err;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      o_filter_err == ((o_cfg.filter_sel != FILTER_800HZ) && (o_cfg.filter_sel != FILTER_1000HZ));
  endproperty
  a_filter_err: assert property (p_filter_err) else $error("filter error flag wrong");

  property p_fields;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (o_cfg.ch0_type == regs[IDX_CHTYPE][CH0_MSB:CH0_LSB])
      && (o_cfg.ch1_type == regs[IDX_CHTYPE][CH1_MSB:CH1_LSB])
      && (o_cfg.filter_sel == regs[IDX_FILTER][FILTER_MSB:FILTER_LSB]);
  endproperty
  a_fields: assert property (p_fields) else $error("field outputs wrong");

  property p_int_mode;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      o_cfg.int_active_low == regs[IDX_INTPIN][INT_MODE_BIT];
  endproperty
  a_int_mode: assert property (p_int_mode) else $error("pin mode wrong");

  property p_locked;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      (i_init_lock && i_req.wr) |=> (regs == $past(regs));
  endproperty
  a_locked: assert property (p_locked) else $error("write passed lock");

  property p_cov_restart;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      $fell(o_path_busy);
  endproperty
  c_restart: cover property (p_cov_restart);

  property p_cov_bad_filter;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      $rose(o_filter_err);
  endproperty
  c_bad_filter: cover property (p_cov_bad_filter);

  property p_cov_addr;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      o_rd_valid && o_rdata != DEFAULT_CLIENT_READ && $past(i_req.addr) == ADDR_CLIENT;
  endproperty
  c_addr: cover property (p_cov_addr);

  property p_valid_inv;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      o_data_valid == !o_path_busy;
  endproperty
  a_valid_inv: assert property (p_valid_inv) else $error("data valid not inverse of busy");

  // Same-value rewrites must leave the running filter alone
  property p_no_change;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      !path_change |=> !o_path_restart;
  endproperty
  a_no_change: assert property (p_no_change) else $error("restart without change");

  property p_cov_locked;
    @(posedge i_clk_sys) disable iff (!i_rst_n)
      i_init_lock && i_req.wr;
  endproperty
  c_locked: cover property (p_cov_locked);

endmodule : scr_config_regs
`default_nettype wire

//--- dv/scr_host_model.sv
// Host controller model driving the configuration register port
`timescale 1ns/1ns
`default_nettype none
module scr_host_model
  import scr_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rd_valid,
  input wire logic [7:0] i_rdata,
  input wire logic i_data_valid,
  output var scr_req_t o_req
);
  initial o_req = '0;

  // Released lines show inverted values so a stale address is never mistaken for a live one
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge i_clk_sys);
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge i_clk_sys);
    o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge i_clk_sys);
    d = i_rdata;
    v = i_rd_valid;
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
  endtask : rd_reg

  // Sensor data is only requested once the path has settled
  task automatic wait_ready(output logic ok);
    int n;
    n = 0;
    while (i_data_valid !== 1'b1 && n < 300) begin
      @(negedge i_clk_sys);
      n++;
    end
    ok = i_data_valid;
  endtask : wait_ready
endmodule : scr_host_model
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking testbench for the sensor configuration register group
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import scr_pkg::*;
;
  logic clk, rst_n, lock, restart, busy, dvalid, ferr, aerr, rd_valid;
  logic [7:0] rdata;
  scr_req_t req;
  scr_cfg_t cfg;
  logic [7:0] mdl [4];
  int n_mismatch, num_checks, seed;

  scr_config_regs i_scr_config_regs (.i_clk_sys(clk), .i_rst_n(rst_n), .i_req(req),
    .i_init_lock(lock), .o_rdata(rdata), .o_rd_valid(rd_valid), .o_cfg(cfg),
    .o_path_restart(restart), .o_path_busy(busy), .o_data_valid(dvalid),
    .o_filter_err(ferr), .o_array_err(aerr));
  scr_host_model i_scr_host_model (.i_clk_sys(clk), .i_rd_valid(rd_valid), .i_rdata(rdata),
    .i_data_valid(dvalid), .o_req(req));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask : chk_bit

  function automatic int idx(input logic [7:0] a);
    case (a)
      8'h3f: return 0;
      8'h40: return 1;
      8'h42: return 2;
      8'h43: return 3;
      default: return -1;
    endcase
  endfunction : idx

  task automatic chk_cfg();
    chk_byte({1'b0, cfg.client_addr}, mdl[0] == 8'h00 ? 8'h60 : {1'b0, mdl[0][6:0]});
    chk_byte({4'h0, cfg.filter_sel}, {4'h0, mdl[1][7:4]});
    chk_byte({4'h0, cfg.ch0_type, cfg.ch1_type}, {4'h0, mdl[2][6:5], mdl[2][3:2]});
    chk_bit(cfg.int_active_low, mdl[3][2]);
    chk_bit(ferr, !(mdl[1][7:4] inside {4'h2, 4'h3}));
    chk_bit(aerr, 1'b0);
  endtask : chk_cfg

  task automatic do_wr(input logic [7:0] a, input logic [7:0] d);
    int k;
    logic chg;
    k = idx(a);
    chg = (k == 1 || k == 2) && !lock && d !== mdl[k];
    i_scr_host_model.wr_reg(a, d);
    if (k >= 0 && !lock) mdl[k] = d;
    chk_bit(restart, chg);
    if (chg) chk_bit(busy, 1'b1);
    chk_cfg();
  endtask : do_wr

  task automatic do_rd(input logic [7:0] a);
    logic [7:0] got, e;
    logic v;
    int k;
    k = idx(a);
    e = (k < 0) ? 8'h00 : (k == 0 && mdl[0] == 8'h00) ? 8'h60 : mdl[k];
    i_scr_host_model.rd_reg(a, got, v);
    chk_bit(v, 1'b1);
    chk_byte(got, e);
  endtask : do_rd

  // Counts the cycles the path stays busy after the last change
  task automatic count_busy();
    int n;
    n = 0;
    while (busy === 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk_byte(8'(n), 8'(RESTART_CYCLES));
    chk_bit(dvalid, 1'b1);
  endtask : count_busy

  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    logic [7:0] v;
    logic ok;
    seed = 55;
    rst_n = 1'b0;
    lock = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    mdl = '{8'h00, 8'h30, 8'h00, 8'h00};
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    chk_cfg();
    foreach (mdl[i]) do_rd(8'h3f + 8'(i) + (i > 1 ? 8'h01 : 8'h00));
    do_rd(8'h41);
    repeat (3) begin
      v = 8'($random(seed)) | 8'h01;
      do_wr(8'h3f, v);
      do_rd(8'h3f);
    end
    do_wr(8'h3f, 8'h00);
    do_rd(8'h3f);
    do_wr(8'h40, 8'h20);
    count_busy();
    do_wr(8'h40, 8'h20);
    do_wr(8'h40, 8'h30);
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    mdl = '{8'h00, 8'h30, 8'h00, 8'h00};
    chk_cfg();
    chk_bit(busy, 1'b0);
    for (int c = 0; c < 16; c++) do_wr(8'h40, {4'(c), 4'(c)});
    for (int t = 0; t < 4; t++) do_wr(8'h42, {1'b0, 2'(t), 1'b0, 2'(3 - t), 2'b00});
    count_busy();
    do_wr(8'h43, 8'h04);
    do_rd(8'h43);
    do_wr(8'h43, 8'h00);
    lock = 1'b1;
    do_wr(8'h40, 8'h20);
    do_wr(8'h3f, 8'h55);
    do_rd(8'h40);
    do_rd(8'h3f);
    lock = 1'b0;
    // Host must wait out a real restart before asking for sensor data
    do_wr(8'h40, 8'h30);
    i_scr_host_model.wait_ready(ok);
    chk_bit(ok, 1'b1);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
